/* File: rtl/rwcm_defines.svh */
// Constants of the reset, watchdog and clock monitor block
`ifndef RWCM_DEFINES_SVH
`define RWCM_DEFINES_SVH
// Register indexes and byte addresses (index times four)
`define RWCM_IDX_SERVICE 8'h1d
`define RWCM_IDX_CONTROL 8'h1e
`define RWCM_ADDR_SERVICE (`RWCM_IDX_SERVICE << 2)
`define RWCM_ADDR_CONTROL (`RWCM_IDX_CONTROL << 2)
// Control register fields
`define RWCM_BIT_SEL_LO 0
`define RWCM_BIT_SEL_HI 1
`define RWCM_BIT_WD_EN 2
`define RWCM_BIT_CM_EN 3
`define RWCM_BIT_FLAG 4
// Service keys
`define RWCM_KEY_FIRST 8'h55
`define RWCM_KEY_SECOND 8'haa
// Reset values forced on the core and peripherals
`define RWCM_SP_RESET 13'h00ff
`define RWCM_TIMER_RESET 16'hfffc
`define RWCM_SER_STAT_RESET 8'hc0
`define RWCM_VEC_HI 13'h1ffe
`define RWCM_VEC_LO 13'h1fff
// Timing
`define RWCM_RST_CYC 3'h4
`define RWCM_WD_BASE 32'h8000
`define RWCM_CLK_NS 25
`define RWCM_CM_TIME_NS 5000
`define RWCM_CM_CYC ((`RWCM_CM_TIME_NS + `RWCM_CLK_NS - 1) / `RWCM_CLK_NS)
`endif

/* File: rtl/rwcm_pkg.sv */
// Types of the reset, watchdog and clock monitor block
package rwcm_pkg;
  // Vector fetch sequencer states
  typedef enum logic [1:0] {
    RWCM_S_RST = 2'b00,
    RWCM_S_VHI = 2'b01,
    RWCM_S_VLO = 2'b10,
    RWCM_S_RUN = 2'b11
  } rwcm_state_t;
endpackage

/* File: rtl/rwcm_top.sv */
// Reset control, software watchdog and clock monitor with APB registers
//
// What this block does
// - Reset clears every port direction register
// - Reset loads stack pointer with 00ff
// - Reset sets the interrupt mask bit
// - Reset clears external, stop and wait latches
// - Reset disables serial unit, sets tx flags
// - Reset disables SPI, clears flags, slave mode
// - Reset clears prescaler, timer to fffc
// - Fetch program counter from 1ffe, 1fff
// - Control register holds enables, period, flag
// - Flag cleared by external reset, set by fail
// - Reading control register clears the flag
// - Clock monitor enable always readable and writable
// - Watchdog resets only while enabled
// - Timeout is 2^15 cycles times 1/4/16/64
// - Reset clears both period select bits
// - Any activity allowed between the two keys, except a service write other than the first key
// - Fail resets drive pin four bus cycles
// - Monitor resets when bus clock goes missing
// - Stop entry with monitor enabled causes reset
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`include "rwcm_defines.svh"

module rwcm_top
  import rwcm_pkg::*;
#(
  parameter int WD_BASE = `RWCM_WD_BASE
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic busClkAlive,
  input wire logic stopEntry,
  output logic rstPinOut,
  output logic rstPinOe,
  input wire logic [31:0] portDirIn,
  output logic [31:0] portDir,
  input wire logic [12:0] stackPtrIn,
  output logic [12:0] stackPtr,
  input wire logic irqMaskIn,
  output logic irqMask,
  input wire logic [2:0] latchesIn,
  output logic [2:0] latches,
  input wire logic [7:0] serCtrlIn,
  output logic [7:0] serCtrl,
  input wire logic [7:0] serStatIn,
  output logic [7:0] serStat,
  input wire logic [7:0] spiCtrlIn,
  output logic [7:0] spiCtrl,
  input wire logic [7:0] timerCtrlIn,
  output logic [7:0] timerCtrl,
  input wire logic [15:0] timerCntIn,
  output logic [15:0] timerCnt,
  input wire logic [7:0] vecData,
  output logic [12:0] vecAddr,
  output logic vecRead,
  output logic cpuHold,
  output logic [12:0] progCount
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic rstPinOe_reg;
  logic [2:0] rstCnt_reg;
  logic wdEn_reg;
  logic cmEn_reg;
  logic [1:0] period_reg;
  logic wdFlag_reg;
  logic armed_reg;
  logic [21:0] wdCnt_reg;
  logic [8:0] cmCnt_reg;
  rwcm_state_t state_reg;
  logic [12:0] vecAddr_reg;
  logic vecRead_reg;
  logic cpuHold_reg;
  logic [12:0] pc_reg;
  logic [31:0] portDir_reg;
  logic [12:0] stackPtr_reg;
  logic irqMask_reg;
  logic [2:0] latches_reg;
  logic [7:0] serCtrl_reg;
  logic [7:0] serStat_reg;
  logic [7:0] spiCtrl_reg;
  logic [7:0] timerCtrl_reg;
  logic [15:0] timerCnt_reg;
  logic intRst;
  logic anyRst;
  logic access;
  logic wrSvc;
  logic wrCtl;
  logic rdCtl;
  logic [21:0] wdLimit;
  logic wdFire;
  logic cmFire;
  logic failEvt;

  // Timeout length for a period select code
  function automatic logic [21:0] wdSpan(input logic [1:0] sel);
    logic [21:0] base;
    base = WD_BASE[21:0];
    wdSpan = base << {sel, 1'b0};
  endfunction

  // Decodes a mapped register address
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == `RWCM_ADDR_SERVICE) || (a == `RWCM_ADDR_CONTROL);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reset sources

  // Internal reset lasts while the stretch counter runs
  assign intRst = (rstCnt_reg != 3'h0);
  assign anyRst = !rst_n || intRst;
  assign failEvt = wdFire || cmFire;

  // Stretch counter for watchdog and monitor resets
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rstCnt_reg <= 3'h0;
    end else if (failEvt) begin
      rstCnt_reg <= `RWCM_RST_CYC;
    end else if (intRst) begin
      rstCnt_reg <= rstCnt_reg - 3'h1;
    end
  end

  // Open-drain reset pin, pulled low during the stretch
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rstPinOe_reg <= 1'b0;
    end else if (failEvt) begin
      rstPinOe_reg <= 1'b1;
    end else if (rstCnt_reg == 3'h1) begin
      rstPinOe_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state

  assign access = psel && penable && pready_reg;
  assign wrSvc = access && pwrite && (paddr == `RWCM_ADDR_SERVICE);
  assign wrCtl = access && pwrite && (paddr == `RWCM_ADDR_CONTROL);
  assign rdCtl = access && !pwrite && (paddr == `RWCM_ADDR_CONTROL);

  // Ready, read data and error for the access phase
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= psel && penable && !pready_reg;
      pslverr_reg <= psel && penable && !pready_reg && !isMapped(paddr);
      prdata_reg <= 32'h0;
      if (psel && penable && !pready_reg && !pwrite &&
          paddr == `RWCM_ADDR_CONTROL) begin
        prdata_reg[`RWCM_BIT_FLAG] <= wdFlag_reg;
        prdata_reg[`RWCM_BIT_CM_EN] <= cmEn_reg;
        prdata_reg[`RWCM_BIT_WD_EN] <= wdEn_reg;
        prdata_reg[`RWCM_BIT_SEL_HI:`RWCM_BIT_SEL_LO] <= period_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register

  // Enables and period select, cleared by any reset
  always_ff @(posedge sys_clk) begin
    if (anyRst) begin
      wdEn_reg <= 1'b0;
      cmEn_reg <= 1'b0;
      period_reg <= 2'b00;
    end else if (wrCtl) begin
      cmEn_reg <= pwdata[`RWCM_BIT_CM_EN];
      wdEn_reg <= pwdata[`RWCM_BIT_WD_EN];
      period_reg <= pwdata[`RWCM_BIT_SEL_HI:`RWCM_BIT_SEL_LO];
    end
  end

  // Fail flag: a new fail wins over a clearing read
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wdFlag_reg <= 1'b0;
    end else if (failEvt) begin
      wdFlag_reg <= 1'b1;
    end else if (rdCtl) begin
      wdFlag_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Watchdog

  assign wdLimit = wdSpan(period_reg);
  assign wdFire = !intRst && wdEn_reg &&
                  (wdCnt_reg == wdLimit - 22'h1);

  // Service sequence: first key arms, second key completes
  always_ff @(posedge sys_clk) begin
    if (anyRst) begin
      armed_reg <= 1'b0;
    end else if (wrSvc) begin
      armed_reg <= (pwdata[7:0] == `RWCM_KEY_FIRST);
    end
  end

  // Free-running count, restarted by service or reset
  always_ff @(posedge sys_clk) begin
    if (anyRst) begin
      wdCnt_reg <= 22'h0;
    end else if (wrSvc && armed_reg &&
                 pwdata[7:0] == `RWCM_KEY_SECOND) begin
      wdCnt_reg <= 22'h0;
    end else if (wdCnt_reg >= wdLimit - 22'h1) begin
      wdCnt_reg <= 22'h0;
    end else begin
      wdCnt_reg <= wdCnt_reg + 22'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock monitor

  assign cmFire = !intRst && cmEn_reg &&
                  (stopEntry ||
                   cmCnt_reg == 9'(`RWCM_CM_CYC));

  // Cycles since the last bus clock activity
  always_ff @(posedge sys_clk) begin
    if (anyRst || busClkAlive || !cmEn_reg) begin
      cmCnt_reg <= 9'h0;
    end else if (cmCnt_reg != 9'(`RWCM_CM_CYC)) begin
      cmCnt_reg <= cmCnt_reg + 9'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset state forced onto core and peripherals

  // Port direction registers, one byte per port
  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_port
      always_ff @(posedge sys_clk) begin
        if (anyRst) begin
          portDir_reg[gp*8 +: 8] <= 8'h00;
        end else begin
          portDir_reg[gp*8 +: 8] <= portDirIn[gp*8 +: 8];
        end
      end
    end
  endgenerate

  // Core: stack pointer, mask bit, interrupt/stop/wait latches
  always_ff @(posedge sys_clk) begin
    if (anyRst) begin
      stackPtr_reg <= `RWCM_SP_RESET;
      irqMask_reg <= 1'b1;
      latches_reg <= 3'h0;
    end else begin
      stackPtr_reg <= stackPtrIn;
      irqMask_reg <= irqMaskIn;
      latches_reg <= latchesIn;
    end
  end

  // Serial units: disabled, flags cleared, tx empty and done set
  always_ff @(posedge sys_clk) begin
    if (anyRst) begin
      serCtrl_reg <= 8'h00;
      serStat_reg <= `RWCM_SER_STAT_RESET;
      spiCtrl_reg <= 8'h00;
    end else begin
      serCtrl_reg <= serCtrlIn;
      serStat_reg <= serStatIn;
      spiCtrl_reg <= spiCtrlIn;
    end
  end

  // Timer: prescaler, output bits and enables cleared, count preset
  always_ff @(posedge sys_clk) begin
    if (anyRst) begin
      timerCtrl_reg <= 8'h00;
      timerCnt_reg <= `RWCM_TIMER_RESET;
    end else begin
      timerCtrl_reg <= timerCtrlIn;
      timerCnt_reg <= timerCntIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Vector fetch after reset

  always_ff @(posedge sys_clk) begin
    if (anyRst) begin
      state_reg <= RWCM_S_RST;
      vecAddr_reg <= `RWCM_VEC_HI;
      vecRead_reg <= 1'b0;
      cpuHold_reg <= 1'b1;
      pc_reg <= 13'h0;
    end else begin
      case (state_reg)
        RWCM_S_RST: begin
          state_reg <= RWCM_S_VHI;
          vecAddr_reg <= `RWCM_VEC_HI;
          vecRead_reg <= 1'b1;
        end
        RWCM_S_VHI: begin
          state_reg <= RWCM_S_VLO;
          pc_reg[12:8] <= vecData[4:0];
          vecAddr_reg <= `RWCM_VEC_LO;
        end
        RWCM_S_VLO: begin
          state_reg <= RWCM_S_RUN;
          pc_reg[7:0] <= vecData;
          vecRead_reg <= 1'b0;
          cpuHold_reg <= 1'b0;
        end
        RWCM_S_RUN: begin
          state_reg <= RWCM_S_RUN;
        end
        default: begin
          state_reg <= RWCM_S_RST;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign rstPinOut = 1'b0;
  assign rstPinOe = rstPinOe_reg;
  assign portDir = portDir_reg;
  assign stackPtr = stackPtr_reg;
  assign irqMask = irqMask_reg;
  assign latches = latches_reg;
  assign serCtrl = serCtrl_reg;
  assign serStat = serStat_reg;
  assign spiCtrl = spiCtrl_reg;
  assign timerCtrl = timerCtrl_reg;
  assign timerCnt = timerCnt_reg;
  assign vecAddr = vecAddr_reg;
  assign vecRead = vecRead_reg;
  assign cpuHold = cpuHold_reg;
  assign progCount = pc_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_fail;
    failEvt;
  endsequence

  sequence s_pin_pulse;
    rstPinOe [*4] ##1 !rstPinOe;
  endsequence

  sequence s_second_key;
    wrSvc && armed_reg && pwdata[7:0] == `RWCM_KEY_SECOND;
  endsequence

  sequence s_fetch;
    vecAddr == `RWCM_VEC_HI && vecRead ##1
    vecAddr == `RWCM_VEC_LO && vecRead ##1 !vecRead && !cpuHold;
  endsequence

  a_pin_four_cycles: assert property (
    s_fail |=> s_pin_pulse)
    else $error("reset pin pulse is not four cycles");

  a_wd_gated: assert property (
    !wdEn_reg && !cmEn_reg && !intRst |=> !rstPinOe)
    else $error("reset pin driven with both sources off");

  a_wd_timeout: assert property (
    !intRst && wdEn_reg && !wrCtl && !wrSvc &&
    wdCnt_reg == wdSpan(period_reg) - 22'h1 |=> rstPinOe && intRst)
    else $error("watchdog timeout did not reset");

  a_flag_set: assert property (
    s_fail |=> wdFlag_reg [*4])
    else $error("fail flag not set after fail reset");

  a_flag_read_clr: assert property (
    rdCtl && !failEvt |=> !wdFlag_reg)
    else $error("control read did not clear flag");

  a_service_restart: assert property (
    s_second_key and !anyRst |=> wdCnt_reg == 22'h0)
    else $error("service sequence did not restart count");

  a_period_reset: assert property (
    intRst |=> period_reg == 2'b00 && !armed_reg && wdCnt_reg == 22'h0)
    else $error("reset left period or counter set");

  a_stop_monitor: assert property (
    stopEntry && cmEn_reg && !intRst |=> rstPinOe ##3 rstPinOe)
    else $error("stop entry with monitor did not reset");

  a_reset_state: assert property (
    intRst |=> stackPtr == `RWCM_SP_RESET && irqMask &&
               timerCnt == `RWCM_TIMER_RESET && portDir == 32'h0)
    else $error("core reset state not forced");

  a_vector_fetch: assert property (
    $fell(intRst) |=> s_fetch)
    else $error("vector fetch order wrong");

endmodule

/* File: test/rwcm_ext_model.sv */
// External system model: pulled-up reset line and vector memory
`timescale 1ns/10ps
module rwcm_ext_model #(
  parameter logic [7:0] VEC_HI = 8'h0a,
  parameter logic [7:0] VEC_LO = 8'h5c
) (
  input wire logic rstPinOut,
  input wire logic rstPinOe,
  input wire logic vecRead,
  input wire logic [12:0] vecAddr,
  output logic [7:0] vecData,
  output logic resetLine
);
  // Line rests high by pull-up, low only while the block pulls it
  assign resetLine = rstPinOe ? rstPinOut : 1'b1;
  // Restart bytes; elsewhere a pattern that moves with the address
  always_comb begin
    if (vecRead && vecAddr == 13'h1ffe)
      vecData = VEC_HI;
    else if (vecRead && vecAddr == 13'h1fff)
      vecData = VEC_LO;
    else
      vecData = ~vecAddr[7:0];
  end
endmodule

/* File: test/rwcm_tb_top.sv */
// Self-checking bench of the reset, watchdog and clock monitor block
`timescale 1ns/10ps
`include "rwcm_defines.svh"
module rwcm_tb_top;
  localparam int WDB = 16;
  localparam logic [7:0] SVC = `RWCM_ADDR_SERVICE;
  localparam logic [7:0] CTL = `RWCM_ADDR_CONTROL;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic busClkAlive = 1'b1;
  logic stopEntry = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rstPinOut, rstPinOe, vecRead, cpuHold;
  logic resetLine, irqMask;
  logic [31:0] portDirIn = 32'h5a5a5a5a;
  logic [12:0] stackPtrIn = 13'h0123;
  logic irqMaskIn = 1'b0;
  logic [2:0] latchesIn = 3'h7;
  logic [7:0] serCtrlIn = 8'hff;
  logic [7:0] serStatIn = 8'h3f;
  logic [7:0] spiCtrlIn = 8'hff;
  logic [7:0] timerCtrlIn = 8'hff;
  logic [15:0] timerCntIn = 16'h1234;
  logic [31:0] portDir;
  logic [12:0] stackPtr, vecAddr, progCount;
  logic [2:0] latches;
  logic [7:0] serCtrl, serStat, spiCtrl, timerCtrl, vecData;
  logic [15:0] timerCnt;
  int failures = 0;
  int numChecks = 0;

  rwcm_top #(.WD_BASE(WDB)) rwcm_top_i (
    .sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .busClkAlive, .stopEntry, .rstPinOut,
    .rstPinOe, .portDirIn, .portDir, .stackPtrIn, .stackPtr,
    .irqMaskIn, .irqMask, .latchesIn, .latches, .serCtrlIn, .serCtrl,
    .serStatIn, .serStat, .spiCtrlIn, .spiCtrl, .timerCtrlIn,
    .timerCtrl, .timerCntIn, .timerCnt, .vecData, .vecAddr, .vecRead,
    .cpuHold, .progCount
  );
  rwcm_ext_model rwcm_ext_model_i (
    .rstPinOut, .rstPinOe, .vecRead, .vecAddr, .vecData, .resetLine
  );

  ////////////////////////////////////////
  // Free-running 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  // Verdict and end of run
  task automatic complete_run();
    $display("Counts: %0d checks, %0d mismatches", numChecks, failures);
    if (failures == 0 && numChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Exact compare of one value
  task automatic chk(input string nm, input logic [31:0] ex, got);
    numChecks++;
    if (got !== ex) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Compare of a measured count within a margin
  task automatic chk_near(input string nm, input int ex, got, tol);
    numChecks++;
    if (got < ex - tol || got > ex + tol) begin
      failures++;
      $display("BAD %s expected %0d seen %0d", nm, ex, got);
    end
  endtask
  // A wait that ran out ends the run
  task automatic hang(input string nm);
    failures++;
    $display("BAD %s expected done seen timeout", nm);
    complete_run();
  endtask
  // One APB transfer; one idle edge after release
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
      hang("pready");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a,
      input logic [31:0] ex);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, ex, r);
    chk("pslverr", 0, e);
  endtask
  // Count edges until the reset line driver is seen on
  task automatic wait_oe(input int lim, output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rstPinOe !== 1'b1 && n < lim);
  endtask
  // Values forced on core and peripherals by any reset
  task automatic chk_forced();
    chk("portDir", 32'h0, portDir);
    chk("stackPtr", `RWCM_SP_RESET, stackPtr);
    chk("irqMask", 1, irqMask);
    chk("latches", 0, latches);
    chk("serCtrl", 0, serCtrl);
    chk("serStat", `RWCM_SER_STAT_RESET, serStat);
    chk("spiCtrl", 0, spiCtrl);
    chk("timerCtrl", 0, timerCtrl);
    chk("timerCnt", `RWCM_TIMER_RESET, timerCnt);
    chk("cpuHold", 1, cpuHold);
  endtask
  // Wait for the restart fetch and judge the program counter
  task automatic boot();
    int n;
    n = 0;
    while (cpuHold !== 1'b0 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    if (cpuHold !== 1'b0)
      hang("boot");
    chk("progCount", 13'h0a5c, progCount);
  endtask
  // Internal reset just seen: pulse, forcing, restart and flag
  task automatic fail_pulse(input string nm);
    int n;
    if (rstPinOe !== 1'b1)
      hang(nm);
    // The edge that showed the driver on is the first pulse cycle;
    // the forced values land on that edge, so look one edge later
    n = 1;
    @(posedge sys_clk);
    chk_forced();
    chk("resetLine", 0, resetLine);
    while (rstPinOe === 1'b1 && n < 9) begin
      n++;
      @(posedge sys_clk);
    end
    if (rstPinOe === 1'b1)
      hang(nm);
    chk(nm, 4, n);
    chk("lineFree", 1, resetLine);
    boot();
    rdchk("flagSet", CTL, 32'h10);
    rdchk("flagRead", CTL, 32'h0);
  endtask
  task automatic stop_pulse();
    stopEntry <= 1'b1;
    @(posedge sys_clk);
    stopEntry <= 1'b0;
  endtask

  ////////////////////////////////////////
  // Outputs follow their inputs once out of reset
  task automatic t_pass();
    portDirIn <= 32'ha5a5a5a5;
    timerCntIn <= 16'h4321;
    serStatIn <= 8'h21;
    repeat (2) @(posedge sys_clk);
    chk("portDir", 32'ha5a5a5a5, portDir);
    chk("timerCnt", 16'h4321, timerCnt);
    chk("serStat", 8'h21, serStat);
    $display("test pass done");
  endtask
  // Control bits, write-only service, unmapped place
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    wr(CTL, 8'h1b);
    rdchk("control", CTL, 32'h0b);
    wr(CTL, 8'h03);
    rdchk("control", CTL, 32'h03);
    rdchk("service", SVC, 32'h0);
    apb(1'b0, 8'h7c, 32'h0, r, e);
    chk("pslverr", 1, e);
    chk("unmapped", 0, r);
    $display("test regs done");
  endtask
  // Timeout length for one period code
  task automatic t_period(input int s);
    int n;
    int p;
    p = WDB << (2 * s);
    wr(CTL, s[7:0]);
    wr(SVC, `RWCM_KEY_FIRST);
    wr(SVC, `RWCM_KEY_SECOND);
    wr(SVC, `RWCM_KEY_FIRST);
    wr(CTL, 8'h04 | s[7:0]);
    wr(SVC, `RWCM_KEY_SECOND);
    wait_oe(p + 8, n);
    chk_near("period", p, n, 1);
    fail_pulse("wdPulse");
    $display("test period %0d done", s);
  endtask
  // Serviced watchdog survives; a wrong key breaks the sequence
  task automatic t_keep();
    int n;
    wr(CTL, 8'h0d);
    repeat (6) begin
      wr(SVC, `RWCM_KEY_FIRST);
      rdchk("control", CTL, 32'h0d);
      wr(SVC, `RWCM_KEY_SECOND);
      repeat (20) @(posedge sys_clk);
    end
    wr(SVC, `RWCM_KEY_FIRST);
    wr(SVC, 8'h12);
    wr(SVC, `RWCM_KEY_SECOND);
    wait_oe(48, n);
    chk("wrongKey", 1, rstPinOe);
    fail_pulse("keepPulse");
    $display("test keep done");
  endtask
  // Disabled watchdog and monitor never reset
  task automatic t_off();
    int n;
    wr(CTL, 8'h00);
    busClkAlive <= 1'b0;
    stop_pulse();
    wait_oe(260, n);
    chk("offOe", 0, rstPinOe);
    busClkAlive <= 1'b1;
    $display("test off done");
  endtask
  // Missing bus clock and stop entry with the monitor on
  task automatic t_mon();
    int n;
    wr(CTL, 8'h08);
    busClkAlive <= 1'b0;
    wait_oe(260, n);
    chk_near("monitor", `RWCM_CM_CYC, n, 2);
    fail_pulse("monPulse");
    busClkAlive <= 1'b1;
    wr(CTL, 8'h08);
    stop_pulse();
    wait_oe(4, n);
    chk("stopOe", 1, rstPinOe);
    fail_pulse("stopPulse");
    $display("test monitor done");
  endtask
  // External reset after a fail clears the flag
  task automatic t_ext();
    int n;
    wr(CTL, 8'h08);
    stop_pulse();
    wait_oe(4, n);
    chk("extOe", 1, rstPinOe);
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    boot();
    rdchk("control", CTL, 32'h0);
    $display("test ext done");
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    chk_forced();
    rst_n <= 1'b1;
    boot();
    rdchk("control", CTL, 32'h0);
    t_pass();
    t_regs();
    for (int s = 0; s < 4; s++) begin
      t_period(s);
    end
    t_keep();
    t_off();
    t_mon();
    t_ext();
    complete_run();
  end
endmodule
